// >>> hw/cscr_pkg.sv
// constants for the cpu status and core control register pair
package cscr_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [3:0] CSCR_OFS_STATUS = 4'h0;
    localparam logic [3:0] CSCR_OFS_CORE = 4'h4;
    localparam logic [3:0] CSCR_OFS_EXT = 4'h8;
    localparam int CSCR_ADDR_W = 4;
    // status field positions
    localparam int ST_C = 0;
    localparam int ST_Z = 1;
    localparam int ST_OV = 2;
    localparam int ST_N = 3;
    localparam int ST_RA = 4;
    localparam int ST_PL_LO = 5;
    localparam int ST_PL_HI = 7;
    localparam int ST_SB = 9;
    localparam int ST_SA = 10;
    localparam int ST_SAB = 11;
    // core control field positions
    localparam int CC_PLH = 3;
    localparam int CC_CRS = 4;
    localparam int CC_SDW = 5;
    localparam int CC_CEB = 6;
    localparam int CC_CEA = 7;
    localparam int CC_DL_LO = 8;
    localparam int CC_DL_HI = 10;
    localparam int CC_EXIT = 11;
    localparam int CC_US_LO = 12;
    localparam int CC_US_HI = 13;
    localparam int CC_VAR = 15;
    // extra register: interrupt_nesting_off at bit 0
    localparam int EX_NEST = 0;
    // reset values and field maxima
    localparam logic [15:0] CSCR_ST_RST = 16'h0000;
    localparam logic [15:0] CSCR_CC_RST = 16'h0000;
    localparam logic [2:0] CSCR_PL_MAX = 3'h7;
    localparam logic [2:0] CSCR_DL_MAX = 3'h7;
    // multiply sign modes
    typedef enum logic [1:0] {
        CSCR_MUL_SS = 2'b00,
        CSCR_MUL_UU = 2'b01,
        CSCR_MUL_MX = 2'b10,
        CSCR_MUL_RSV = 2'b11
    } cscr_mul_t;
endpackage : cscr_pkg

// >>> hw/cscr_flags.sv
`timescale 1ns/10ps
// alu flag update unit: computes next n, ov, z, c from an alu result
module cscr_flags
    import cscr_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // alu result and per-flag update enables
    input wire logic alu_valid,
    input wire logic [W-1:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_wrap,
    input wire logic upd_n,
    input wire logic upd_ov,
    input wire logic upd_z,
    input wire logic upd_c,
    input wire logic z_sticky,
    // current flags and next flags
    input wire logic [3:0] flags_cur,
    output logic [3:0] flags_nxt
);
    logic res_zero;
    assign res_zero = (alu_result == '0);
    // per-flag merge: untouched flags keep their value
    always_comb begin
        flags_nxt = flags_cur;
        if (alu_valid) begin
            if (upd_n) flags_nxt[ST_N] = alu_result[W-1]; // R5 R20
            if (upd_ov) flags_nxt[ST_OV] = alu_wrap; // R6 R20
            if (upd_c) flags_nxt[ST_C] = alu_carry; // R8 R20
            if (upd_z) begin
                if (!res_zero) flags_nxt[ST_Z] = 1'b0; // R7
                else if (!z_sticky) flags_nxt[ST_Z] = 1'b1;
            end
        end
    end
    a_flag_hold: assert property (@(posedge clk) disable iff (rst) // R20
        !alu_valid |-> flags_nxt == flags_cur)
        else $error("flags changed without alu result");
    a_zero_clear: assert property (@(posedge clk) disable iff (rst) // R7
        alu_valid && upd_z && !res_zero |-> !flags_nxt[ST_Z])
        else $error("zero flag not cleared on nonzero result");
endmodule : cscr_flags

// >>> hw/cscr_regs.sv
`timescale 1ns/10ps
// cpu status and core control registers with wishbone slave
// Functional notes
// R1: three-bit priority level in status bits 7-5
// R2: high bit adds eight; high disables interrupts
// R3: priority field read-only while nesting is off
// R4: repeat_active mirrors single-instruction repeat loop
// R5: negative flag follows result sign
// R6: signed wrap flag marks two's-complement overflow
// R7: zero flag cleared on nonzero, may stick
// R8: carry flag is carry out or borrow
// R9: writes change clip flags, combined clear clears both
// R10: software avoids bit ops on clip flags
// R11: bit 15 picks variable or fixed latency
// R12: bits 13-12 pick multiply signedness, 11 reserved; code uses bit 11 as the loop exit bit
// R13: writing one ends DO loop at iteration end
// R14: loop_nest_depth reports active DO loops
// R15: acc A saturates when its enable set
// R16: acc B saturates when its enable set
// R17: data stores saturate when store enable set
// R18: clip_range_select picks super or normal saturation
// R19: signed, unsigned, mixed multiply treatment supported
// R20: flags change only on affecting instructions
module cscr_regs
    import cscr_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CSCR_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // alu status from the execution unit
    input wire logic alu_valid,
    input wire logic [W-1:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_wrap,
    input wire logic upd_n,
    input wire logic upd_ov,
    input wire logic upd_z,
    input wire logic upd_c,
    input wire logic z_sticky,
    // loop and saturation status from the datapath
    input wire logic repeat_run,
    input wire logic do_push,
    input wire logic do_pop,
    input wire logic clip_a_evt,
    input wire logic clip_b_evt,
    // priority level set by exception logic
    input wire logic pl_load,
    input wire logic [3:0] pl_value,
    // control outputs to the core
    output logic [3:0] cpu_priority_full,
    output logic user_irq_off,
    output logic exc_var_latency,
    output logic [1:0] multiply_sign_select,
    output logic mul_a_signed,
    output logic mul_b_signed,
    output logic loop_exit_req,
    output logic acc_a_clip_enable,
    output logic acc_b_clip_enable,
    output logic store_clip_enable,
    output logic clip_range_select
);
    logic [2:0] pl_q;
    logic plh_q;
    logic ra_q;
    logic [3:0] fl_q;
    logic [3:0] fl_d;
    logic sa_q;
    logic sb_q;
    logic var_q;
    logic [1:0] us_q;
    logic exit_q;
    logic [2:0] dl_q;
    logic [3:0] sat_q;
    logic nest_q;
    logic ack_q;
    logic [31:0] rd_q;
    logic req;
    logic wr_st;
    logic wr_cc;
    logic wr_ex;
    logic [15:0] st_rd;
    logic [15:0] cc_rd;

    // merges byte lanes of a write into an old 16-bit value
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        lane_merge = old;
        if (sel[0]) lane_merge[7:0] = dat[7:0];
        if (sel[1]) lane_merge[15:8] = dat[15:8];
    endfunction : lane_merge

    // bus decode, one write strobe per register on the acking edge
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_st = req && wb_we_i && (wb_adr_i == CSCR_OFS_STATUS);
    assign wr_cc = req && wb_we_i && (wb_adr_i == CSCR_OFS_CORE);
    assign wr_ex = req && wb_we_i && (wb_adr_i == CSCR_OFS_EXT);

    // readback images
    assign st_rd = {4'h0, sa_q | sb_q, sa_q, sb_q, 1'b0, pl_q, ra_q, fl_q};
    assign cc_rd = {var_q, 1'b0, us_q, 1'b0, dl_q, sat_q, plh_q, 3'h0};

    // flag merge unit
    cscr_flags #(.W(W)) u_flags (
        .clk(clk),
        .rst(rst),
        .alu_valid(alu_valid),
        .alu_result(alu_result),
        .alu_carry(alu_carry),
        .alu_wrap(alu_wrap),
        .upd_n(upd_n),
        .upd_ov(upd_ov),
        .upd_z(upd_z),
        .upd_c(upd_c),
        .z_sticky(z_sticky),
        .flags_cur(fl_q),
        .flags_nxt(fl_d)
    );

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (wb_adr_i)
                CSCR_OFS_STATUS: rd_q <= {16'h0000, st_rd};
                CSCR_OFS_CORE: rd_q <= {16'h0000, cc_rd};
                CSCR_OFS_EXT: rd_q <= {31'h0, nest_q};
                default: rd_q <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    // nesting disable control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nest_q <= 1'b0;
        end else if (wr_ex && wb_sel_i[0]) begin
            nest_q <= wb_dat_i[EX_NEST];
        end
    end

    // priority level: exception load wins, status write blocked by nesting off, plh write not blocked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pl_q <= CSCR_ST_RST[ST_PL_HI:ST_PL_LO];
            plh_q <= CSCR_CC_RST[CC_PLH];
        end else if (pl_load) begin
            pl_q <= pl_value[2:0]; // R1
            plh_q <= pl_value[3];
        end else begin
            if (wr_st && wb_sel_i[0] && !nest_q) begin
                pl_q <= wb_dat_i[ST_PL_HI:ST_PL_LO]; // R1 R3
            end
            if (wr_cc && wb_sel_i[0]) begin
                plh_q <= wb_dat_i[CC_PLH];
            end
        end
    end
    assign cpu_priority_full = {plh_q, pl_q}; // R2
    assign user_irq_off = plh_q || (pl_q == CSCR_PL_MAX); // R1 R2

    // repeat loop activity follows the execution unit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ra_q <= CSCR_ST_RST[ST_RA];
        end else begin
            ra_q <= repeat_run; // R4
        end
    end

    // alu flags: hardware result wins over a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fl_q <= CSCR_ST_RST[3:0];
        end else if (alu_valid) begin
            fl_q <= fl_d; // R5 R6 R7 R8 R20
        end else if (wr_st && wb_sel_i[0]) begin
            fl_q <= wb_dat_i[3:0];
        end
    end

    // clip flags: saturation events set, software writes or clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sa_q <= CSCR_ST_RST[ST_SA];
            sb_q <= CSCR_ST_RST[ST_SB];
        end else begin
            if (wr_st && wb_sel_i[1]) begin
                if (!wb_dat_i[ST_SAB]) begin
                    sa_q <= clip_a_evt; // R9
                    sb_q <= clip_b_evt;
                end else begin
                    sa_q <= wb_dat_i[ST_SA] | clip_a_evt; // R9 R10
                    sb_q <= wb_dat_i[ST_SB] | clip_b_evt;
                end
            end else begin
                if (clip_a_evt) sa_q <= 1'b1;
                if (clip_b_evt) sb_q <= 1'b1;
            end
        end
    end

    // core control settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            var_q <= CSCR_CC_RST[CC_VAR];
            us_q <= CSCR_CC_RST[CC_US_HI:CC_US_LO];
            sat_q <= CSCR_CC_RST[CC_CEA:CC_CRS];
        end else if (wr_cc) begin
            if (wb_sel_i[1]) begin
                var_q <= wb_dat_i[CC_VAR]; // R11
                us_q <= wb_dat_i[CC_US_HI:CC_US_LO]; // R12
            end
            if (wb_sel_i[0]) begin
                sat_q <= wb_dat_i[CC_CEA:CC_CRS]; // R15 R16 R17 R18
            end
        end
    end

    // early loop exit: write one requests while a DO loop is active, loop end clears, 0 no effect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exit_q <= 1'b0;
        end else if (wr_cc && wb_sel_i[1] && wb_dat_i[CC_EXIT]) begin
            exit_q <= (dl_q != 3'h0); // R13
        end else if (do_pop) begin
            exit_q <= 1'b0;
        end
    end

    // loop nest depth counter, saturating at seven
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dl_q <= CSCR_CC_RST[CC_DL_HI:CC_DL_LO];
        end else if (do_push && !do_pop && dl_q != CSCR_DL_MAX) begin
            dl_q <= dl_q + 3'h1; // R14
        end else if (do_pop && !do_push && dl_q != 3'h0) begin
            dl_q <= dl_q - 3'h1; // R14
        end
    end

    // control outputs
    assign exc_var_latency = var_q; // R11
    assign multiply_sign_select = us_q; // R12 R19
    assign mul_a_signed = (us_q == CSCR_MUL_SS) || (us_q == CSCR_MUL_MX); // R19
    assign mul_b_signed = (us_q == CSCR_MUL_SS); // R19
    assign loop_exit_req = exit_q; // R13
    assign acc_a_clip_enable = sat_q[CC_CEA-CC_CRS]; // R15
    assign acc_b_clip_enable = sat_q[CC_CEB-CC_CRS]; // R16
    assign store_clip_enable = sat_q[CC_SDW-CC_CRS]; // R17
    assign clip_range_select = sat_q[0]; // R18

    a_prio_locked: assert property (@(posedge clk) disable iff (rst) // R3
        nest_q && !pl_load |=> $stable(pl_q))
        else $error("priority changed while nesting off");
    a_irq_off: assert property (@(posedge clk) disable iff (rst) // R2
        plh_q |-> user_irq_off && cpu_priority_full >= 4'h8)
        else $error("high priority bit did not disable interrupts");
    a_prio_full: assert property (@(posedge clk) disable iff (rst) // R1
        wr_st && wb_sel_i[0] && !nest_q && !pl_load
        |=> pl_q == $past(wb_dat_i[ST_PL_HI:ST_PL_LO]))
        else $error("priority level write not taken");
    a_repeat_flag: assert property (@(posedge clk) disable iff (rst) // R4
        repeat_run |=> ra_q)
        else $error("repeat flag not set");
    a_neg_flag: assert property (@(posedge clk) disable iff (rst) // R5
        alu_valid && upd_n |=> fl_q[ST_N] == $past(alu_result[W-1]))
        else $error("negative flag wrong");
    a_wrap_flag: assert property (@(posedge clk) disable iff (rst) // R6
        alu_valid && upd_ov |=> fl_q[ST_OV] == $past(alu_wrap))
        else $error("wrap flag wrong");
    a_carry_flag: assert property (@(posedge clk) disable iff (rst) // R8
        alu_valid && upd_c |=> fl_q[ST_C] == $past(alu_carry))
        else $error("carry flag wrong");
    a_clip_clear: assert property (@(posedge clk) disable iff (rst) // R9
        wr_st && wb_sel_i[1] && !wb_dat_i[ST_SAB] && !clip_a_evt |=> !sa_q)
        else $error("combined clear did not clear flag a");
    a_depth_up: assert property (@(posedge clk) disable iff (rst) // R14
        do_push && !do_pop && dl_q < CSCR_DL_MAX |=> dl_q == $past(dl_q) + 3'h1)
        else $error("nest depth did not count up");
    a_exit_hold: assert property (@(posedge clk) disable iff (rst) // R13
        exit_q && !do_pop && !wr_cc |=> exit_q)
        else $error("loop exit request lost");
    a_bus_ack: assert property (@(posedge clk) disable iff (rst)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
endmodule : cscr_regs

// >>> bench/cscr_exec_model.sv
`timescale 1ns/10ps
// execution unit model: adds two operands and reports result status
module cscr_exec_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // operation request
    input wire logic go,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    // result status
    output logic alu_valid,
    output logic [15:0] alu_result,
    output logic alu_carry,
    output logic alu_wrap
);
    logic [16:0] sum;
    // seventeen-bit sum keeps the carry out
    assign sum = {1'b0, op_a} + {1'b0, op_b};
    // one-cycle result pulse; result scrambled while idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alu_valid <= 1'b0;
            alu_result <= 16'h0000;
            alu_carry <= 1'b0;
            alu_wrap <= 1'b0;
        end else begin
            alu_valid <= go;
            alu_result <= go ? sum[15:0] : ~alu_result;
            alu_carry <= go ? sum[16] : ~alu_carry;
            alu_wrap <= go ? (op_a[15] == op_b[15]) && (sum[15] != op_a[15]) : 1'b0;
        end
    end
endmodule : cscr_exec_model

// >>> bench/cscr_regs_test.sv
`timescale 1ns/10ps
// self-checking bench for the status and control registers
module cscr_regs_test;
    import cscr_pkg::*;
    logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, z_sticky, repeat_run;
    logic [3:0] wb_adr_i, wb_sel_i, upd, evt, cpu_priority_full;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic alu_valid, alu_carry, alu_wrap, pl_load, user_irq_off, exc_var_latency;
    logic [15:0] alu_result, op_a, op_b, cc;
    logic [1:0] multiply_sign_select;
    logic mul_a_signed, mul_b_signed, loop_exit_req, acc_a_clip_enable, acc_b_clip_enable;
    logic store_clip_enable, clip_range_select, ra, sa, sb;
    logic [3:0] pl_value, fl;
    logic [2:0] pl, dl;
    logic [31:0] q[$];
    int n_errors, samples_checked, seed, k;
    // clock at 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    cscr_regs dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alu_valid(alu_valid),
        .alu_result(alu_result), .alu_carry(alu_carry), .alu_wrap(alu_wrap),
        .upd_n(upd[3]), .upd_ov(upd[2]), .upd_z(upd[1]), .upd_c(upd[0]),
        .z_sticky(z_sticky), .repeat_run(repeat_run), .do_push(evt[3]), .do_pop(evt[2]),
        .clip_a_evt(evt[1]), .clip_b_evt(evt[0]), .pl_load(pl_load), .pl_value(pl_value),
        .cpu_priority_full(cpu_priority_full), .user_irq_off(user_irq_off),
        .exc_var_latency(exc_var_latency), .multiply_sign_select(multiply_sign_select),
        .mul_a_signed(mul_a_signed), .mul_b_signed(mul_b_signed),
        .loop_exit_req(loop_exit_req), .acc_a_clip_enable(acc_a_clip_enable),
        .acc_b_clip_enable(acc_b_clip_enable), .store_clip_enable(store_clip_enable),
        .clip_range_select(clip_range_select));
    cscr_exec_model exu (.clk(clk), .rst(rst), .go(go), .op_a(op_a), .op_b(op_b),
        .alu_valid(alu_valid), .alu_result(alu_result), .alu_carry(alu_carry),
        .alu_wrap(alu_wrap));
    // expected status word from the bench's own flag copies
    function automatic logic [15:0] st_exp();
        return {4'h0, sa | sb, sa, sb, 1'b0, pl, ra, fl};
    endfunction : st_exp
    // expected control outputs from the written control word
    function automatic logic [31:0] want();
        return {18'h0, ~cc[12], cc[13:12] == 2'b00, cc[15], cc[13:12], cc[7:4],
            cc[3] | (pl == 3'h7), cc[3], pl};
    endfunction : want
    function automatic logic [31:0] got();
        return {18'h0, mul_a_signed, mul_b_signed, exc_var_latency, multiply_sign_select,
            acc_a_clip_enable, acc_b_clip_enable, store_clip_enable, clip_range_select,
            user_irq_off, cpu_priority_full};
    endfunction : got
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] adr, input logic [15:0] dat);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {16'h0000, dat};
        // wait for ack however long it takes; the watchdog bounds the run
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [3:0] adr, input logic [15:0] exp);
        q.push_back({16'h0000, exp});
        wb(1'b0, adr, 16'h0000);
    endtask : rd
    // one addition through the model, expectation kept beside it
    task automatic alu(input logic [15:0] a, input logic [15:0] b, input logic [3:0] u,
        input logic zs);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        @(posedge clk);
        op_a <= a;
        op_b <= b;
        go <= 1'b1;
        upd <= u;
        z_sticky <= zs;
        @(posedge clk);
        go <= 1'b0;
        if (u[3]) fl[3] = s[15];
        if (u[2]) fl[2] = (a[15] == b[15]) && (s[15] != a[15]);
        if (u[1]) fl[1] = (s[15:0] != 16'h0000) ? 1'b0 : (zs ? fl[1] : 1'b1);
        if (u[0]) fl[0] = s[16];
        @(posedge clk);
        rd(CSCR_OFS_STATUS, st_exp());
    endtask : alu
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 4'h0;
    endtask : pulse
    // read answers compared oldest first
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) check(wb_dat_o, q.pop_front());
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        check(32'h0, 32'h1);
        finish_test();
    end
    // main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, go, z_sticky, repeat_run, pl_load} = 7'h00;
        {wb_adr_i, upd, evt, pl_value, wb_dat_i, op_a, op_b} = 80'h0;
        wb_sel_i = 4'h3;
        {fl, pl, dl, ra, sa, sb, cc} = 32'h0;
        n_errors = 0;
        samples_checked = 0;
        seed = 49;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(CSCR_OFS_STATUS, 16'h0000);
        rd(CSCR_OFS_CORE, 16'h0000);
        wb(1'b1, 4'hC, 16'hFFFF);
        rd(4'hC, 16'h0000);
        check(got(), want());
        $display("test reset done");
        cc = 16'hB0F8;
        wb(1'b1, CSCR_OFS_CORE, 16'hFFFF);
        rd(CSCR_OFS_CORE, cc);
        for (k = 0; k < 4; k++) begin
            cc = {2'b10, k[1:0], 4'h0, 8'hB0};
            wb(1'b1, CSCR_OFS_CORE, cc);
            check(got(), want());
        end
        $display("test control done");
        for (k = 0; k < 9; k++) begin
            cc = (k == 8) ? 16'h0008 : 16'h0000;
            pl = k[2:0];
            wb(1'b1, CSCR_OFS_CORE, cc);
            wb(1'b1, CSCR_OFS_STATUS, st_exp());
            check(got(), want());
        end
        wb(1'b1, CSCR_OFS_EXT, 16'h0001);
        wb(1'b1, CSCR_OFS_STATUS, 16'h0040);
        rd(CSCR_OFS_STATUS, st_exp());
        @(posedge clk);
        pl_load <= 1'b1;
        pl_value <= 4'h3;
        @(posedge clk);
        pl_load <= 1'b0;
        {cc[3], pl} = 4'h3;
        @(posedge clk);
        check(got(), want());
        wb(1'b1, CSCR_OFS_EXT, 16'h0000);
        $display("test priority done");
        alu(16'h0000, 16'h0000, 4'hF, 1'b0);
        alu(16'h0001, 16'h0000, 4'hF, 1'b1);
        alu(16'h0000, 16'h0000, 4'hF, 1'b1);
        alu(16'h7FFF, 16'h0001, 4'hF, 1'b0);
        alu(16'hFFFF, 16'h0001, 4'h0, 1'b0);
        alu(16'hFFFF, 16'h0001, 4'hF, 1'b0);
        for (k = 0; k < 8; k++) alu($random(seed), $random(seed), $random(seed), $random(seed));
        $display("test flags done");
        repeat_run <= 1'b1;
        ra = 1'b1;
        rd(CSCR_OFS_STATUS, st_exp());
        repeat_run <= 1'b0;
        ra = 1'b0;
        rd(CSCR_OFS_STATUS, st_exp());
        for (k = 0; k < 7; k++) pulse(4'h8);
        dl = 3'h7;
        rd(CSCR_OFS_CORE, cc | {5'h0, dl, 8'h0});
        wb(1'b1, CSCR_OFS_CORE, cc | 16'h0800);
        check(loop_exit_req, 1'b1);
        pulse(4'h4);
        dl = 3'h6;
        @(posedge clk);
        check(loop_exit_req, 1'b0);
        rd(CSCR_OFS_CORE, cc | {5'h0, dl, 8'h0});
        $display("test loops done");
        pulse(4'h2);
        sa = 1'b1;
        rd(CSCR_OFS_STATUS, st_exp());
        pulse(4'h1);
        sb = 1'b1;
        rd(CSCR_OFS_STATUS, st_exp());
        {sa, sb} = 2'b00;
        wb(1'b1, CSCR_OFS_STATUS, st_exp());
        rd(CSCR_OFS_STATUS, st_exp());
        sa = 1'b1;
        wb(1'b1, CSCR_OFS_STATUS, st_exp());
        rd(CSCR_OFS_STATUS, st_exp());
        $display("test clip flags done");
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule : cscr_regs_test
